// [ssrf_framer.sv]
`timescale 1ns/10ps
`default_nettype none
module ssrf_framer (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Serial link pins
  input  wire logic                   linkSclk,
  input  wire logic                   chipSelect_n,
  input  wire logic                   dataIn,
  output var  logic                   dataOut,
  output var  logic                   dataOutEn,
  // Device state
  input  wire ssrf_pkg::ssrf_exc_s    exceptions,
  input  wire logic                   oscFault,
  input  wire logic                   signed_output_select,
  input  wire ssrf_pkg::ssrf_accel_s  accelX,
  input  wire ssrf_pkg::ssrf_accel_s  accelY,
  input  wire logic [7:0]             regReadData,
  input  wire logic [7:0]             statusCode,
  // Register port
  output var  logic [7:0]             regPointer,
  output var  logic                   regWrite,
  output var  logic [7:0]             regWriteData,
  output var  logic                   frameDone
);
  logic sclkS;
  logic csSel;
  logic dinS;
  logic sclkPrev_r;
  logic csPrev_r;
  logic [15:0] shiftIn_r;
  logic [15:0] shiftOut_r;
  logic [4:0]  bitCnt_r;
  logic        transientNext_r;

  ssrf_sync uSclk (.clk(clk), .reset_n(reset_n), .pinIn(linkSclk), .levelOut(sclkS));
  // Select synchronised active high, so its reset level is the idle bus and no false edge follows reset
  ssrf_sync uCs (.clk(clk), .reset_n(reset_n), .pinIn(!chipSelect_n), .levelOut(csSel));
  ssrf_sync uDin (.clk(clk), .reset_n(reset_n), .pinIn(dataIn), .levelOut(dinS));

  wire csActive = csSel;
  wire csFall   = !csPrev_r && csSel;
  wire csRise   = csPrev_r && !csSel;
  wire sclkRise = !sclkPrev_r && sclkS && csActive;
  wire sclkFall = sclkPrev_r && !sclkS && csActive;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkPrev_r <= 1'b0;
      csPrev_r   <= 1'b0;
    end else begin
      sclkPrev_r <= sclkS;
      csPrev_r   <= csSel;
    end
  end

  // Command decode of the previous frame selects this frame's reply
  logic [15:0] cmd_r;
  logic        cmdValid_r;
  wire  [1:0]  cmdType = cmd_r[15:14];
  wire         cmdAd   = cmd_r[ssrf_pkg::POS_AD];
  wire         cmdRw   = cmd_r[ssrf_pkg::POS_RW];
  wire         badAxis = cmdValid_r && (cmdType == ssrf_pkg::TT_BAD);

  // Exception class, highest priority first
  logic [1:0] excClass;
  logic       behavOne;
  always_comb begin
    behavOne = exceptions.selfTest ^ exceptions.hold;
    if (exceptions.transient || exceptions.badAxis || exceptions.clkFault || exceptions.parFault
        || badAxis || transientNext_r) begin
      excClass = ssrf_pkg::EC_TRANS;
    end else if (exceptions.resetExc || exceptions.critical) begin
      excClass = ssrf_pkg::EC_CRIT;
    end else if (behavOne) begin
      excClass = ssrf_pkg::EC_BEHAV;
    end else begin
      excClass = ssrf_pkg::EC_NONE;
    end
  end

  // Accel value encoding
  function automatic logic [10:0] encode(input ssrf_pkg::ssrf_accel_s a, input logic sgn);
    logic [10:0] v;
    v = a.value;
    if (a.overflow) begin
      v = ssrf_pkg::CODE_OVERFLOW;
    end else if (a.underflow) begin
      v = ssrf_pkg::CODE_UNDERFLOW;
    end else if (a.overRange || v > ssrf_pkg::CODE_MAX_POS) begin
      v = ssrf_pkg::CODE_OVERRANGE;
    end else if (a.underRange || v < ssrf_pkg::CODE_MIN_NEG) begin
      v = ssrf_pkg::CODE_UNDERRNG;
    end
    // Signed form shifts zero from 1024 to 0
    if (sgn) begin
      v = v ^ ssrf_pkg::CODE_ZERO;
    end
    return v;
  endfunction

  logic [15:0] reply;
  logic [10:0] accCode;
  logic [7:0]  lowByte;
  always_comb begin
    reply   = '0;
    accCode = encode((cmdType == ssrf_pkg::TT_YAXIS) ? accelY : accelX, signed_output_select);
    lowByte = cmdAd ? regReadData : regPointer;
    if (!cmdValid_r || cmdType != ssrf_pkg::TT_REG) begin
      if (excClass == ssrf_pkg::EC_CRIT) begin
        // Fixed pattern is already odd; recomputing parity would clear bit 12
        reply = {{15{1'b1}}, 1'b0};
      end else begin
        if (excClass == ssrf_pkg::EC_TRANS) begin
          accCode = (badAxis || exceptions.badAxis) ? ssrf_pkg::CODE_BAD_AXIS :
                    (exceptions.clkFault ? ssrf_pkg::CODE_CLK_FAULT : ssrf_pkg::CODE_PAR_FAULT);
          reply = {3'h7, 1'b0, accCode, 1'b0};
        end else begin
          reply = {(exceptions.selfTest ^ exceptions.hold), cmdType, 1'b0, accCode, 1'b0};
        end
        reply[ssrf_pkg::POS_PAR_ACC] = ~^reply;
      end
    end else begin
      reply[15:13] = (excClass == ssrf_pkg::EC_NONE) ? 3'h0 : 3'h7;
      reply[ssrf_pkg::POS_AD_RSP] = cmdAd;
      reply[ssrf_pkg::POS_RW_RSP] = cmdRw;
      reply[9:8] = excClass;
      if (excClass == ssrf_pkg::EC_TRANS) begin
        reply[7:0] = statusCode;
      end else if (cmdRw) begin
        reply[7:0] = cmdAd ? regPointer : 8'h00;
      end else begin
        reply[7:0] = lowByte;
      end
      reply[ssrf_pkg::POS_PAR_REG] = ~^reply;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftIn_r <= '0;
      bitCnt_r  <= '0;
    end else if (csFall) begin
      bitCnt_r <= '0;
    end else if (sclkRise && bitCnt_r <= 5'(ssrf_pkg::FRAME_BITS)) begin
      // Counts one past a frame, so an overlong frame is refused too
      shiftIn_r <= {shiftIn_r[14:0], dinS};
      bitCnt_r  <= bitCnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftOut_r <= '0;
    end else if (csFall) begin
      shiftOut_r <= reply;
    end else if (sclkFall) begin
      shiftOut_r <= {shiftOut_r[14:0], 1'b0};
    end
  end

  // Frames of other than 16 clocks are dropped
  wire goodFrame = csRise && (bitCnt_r == 5'(ssrf_pkg::FRAME_BITS));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r           <= '0;
      cmdValid_r      <= 1'b0;
      transientNext_r <= 1'b0;
    end else if (csRise) begin
      cmd_r           <= shiftIn_r;
      cmdValid_r      <= goodFrame;
      transientNext_r <= !goodFrame || (goodFrame && !(^shiftIn_r));
    end
  end

  // Register side effects; blocked unless the exception class is none
  wire doReg = goodFrame && shiftIn_r[15:14] == ssrf_pkg::TT_REG && (^shiftIn_r)
               && shiftIn_r[ssrf_pkg::POS_RW] && excClass == ssrf_pkg::EC_NONE;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regPointer   <= '0;
      regWrite     <= 1'b0;
      regWriteData <= '0;
      frameDone    <= 1'b0;
    end else begin
      frameDone <= goodFrame;
      regWrite  <= 1'b0;
      if (doReg && !shiftIn_r[ssrf_pkg::POS_AD]) begin
        regPointer <= shiftIn_r[7:0];
      end
      if (doReg && shiftIn_r[ssrf_pkg::POS_AD] && regPointer == ssrf_pkg::ADDR_DEVICE_CONTROL_REGISTER) begin
        regWrite     <= 1'b1;
        regWriteData <= shiftIn_r[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dataOut   <= 1'b0;
      dataOutEn <= 1'b0;
    end else begin
      dataOutEn <= csActive;
      dataOut   <= oscFault ? 1'b1 : shiftOut_r[ssrf_pkg::POS_TOP];
    end
  end

  property p_osc_high;
    @(posedge clk) disable iff (!reset_n) oscFault && csActive |=> dataOut && dataOutEn;
  endproperty
  a_osc_high: assert property (p_osc_high) else $error("oscillator fault output not high");
  property p_dev_only;
    @(posedge clk) disable iff (!reset_n) regWrite |-> $past(regPointer) == ssrf_pkg::ADDR_DEVICE_CONTROL_REGISTER;
  endproperty
  a_dev_only: assert property (p_dev_only) else $error("write outside control register");
  property p_crit_acc;
    @(posedge clk) disable iff (!reset_n)
      csFall && cmdValid_r && cmdType != ssrf_pkg::TT_REG && excClass == ssrf_pkg::EC_CRIT
      |=> shiftOut_r == 16'hFFFE;
  endproperty
  a_crit_acc: assert property (p_crit_acc) else $error("critical accel reply wrong");
  property p_trans_ec;
    @(posedge clk) disable iff (!reset_n)
      csFall && cmdValid_r && cmdType == ssrf_pkg::TT_REG && excClass == ssrf_pkg::EC_TRANS
      |=> shiftOut_r[9:8] == 2'h3 && shiftOut_r[15:13] == 3'h7;
  endproperty
  a_trans_ec: assert property (p_trans_ec) else $error("transient register reply wrong");
  property p_parity;
    @(posedge clk) disable iff (!reset_n) csFall |=> ^shiftOut_r;
  endproperty
  a_parity: assert property (p_parity) else $error("reply parity not odd");
  property p_bad_axis;
    @(posedge clk) disable iff (!reset_n)
      csFall && badAxis |=> shiftOut_r[15:13] == 3'h7 && shiftOut_r[11:1] == ssrf_pkg::CODE_BAD_AXIS;
  endproperty
  a_bad_axis: assert property (p_bad_axis) else $error("bad axis reply wrong");
  property p_echo;
    @(posedge clk) disable iff (!reset_n)
      csFall && cmdValid_r && cmdType == ssrf_pkg::TT_REG
      |=> shiftOut_r[ssrf_pkg::POS_RW_RSP] == $past(cmdRw) && shiftOut_r[ssrf_pkg::POS_AD_RSP] == $past(cmdAd);
  endproperty
  a_echo: assert property (p_echo) else $error("selections not echoed");
  property p_no_zero;
    @(posedge clk) disable iff (!reset_n)
      csFall && (!cmdValid_r || cmdType != ssrf_pkg::TT_REG) && !signed_output_select
      && (excClass == ssrf_pkg::EC_NONE || excClass == ssrf_pkg::EC_BEHAV) |=> shiftOut_r[11:1] != 11'h000;
  endproperty
  a_no_zero: assert property (p_no_zero) else $error("code zero produced");
  c_frame: cover property (@(posedge clk) goodFrame);
  c_regw: cover property (@(posedge clk) regWrite);
  c_trans: cover property (@(posedge clk) csFall && excClass == ssrf_pkg::EC_TRANS);
endmodule
`default_nettype wire

// [ssrf_pkg.sv]
`default_nettype none
package ssrf_pkg;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned SYNC_DEPTH = 3;

  // Transfer type codes, top two command bits
  localparam logic [1:0] TT_REG   = 2'h0;
  localparam logic [1:0] TT_XAXIS = 2'h1;
  localparam logic [1:0] TT_YAXIS = 2'h2;
  localparam logic [1:0] TT_BAD   = 2'h3;

  // Exception classes in register replies
  localparam logic [1:0] EC_NONE  = 2'h0;
  localparam logic [1:0] EC_BEHAV = 2'h1;
  localparam logic [1:0] EC_CRIT  = 2'h2;
  localparam logic [1:0] EC_TRANS = 2'h3;

  // Reserved 11-bit acceleration codes, the value range limits and zero
  localparam logic [10:0] CODE_CRIT      = 11'h7FF;
  localparam logic [10:0] CODE_BAD_AXIS  = 11'h7FE;
  localparam logic [10:0] CODE_OVERFLOW  = 11'h7FD;
  localparam logic [10:0] CODE_OVERRANGE = 11'h7FC;
  localparam logic [10:0] CODE_MAX_POS   = 11'h7FB;
  localparam logic [10:0] CODE_ZERO      = 11'h400;
  localparam logic [10:0] CODE_MIN_NEG   = 11'h005;
  localparam logic [10:0] CODE_UNDERRNG  = 11'h004;
  localparam logic [10:0] CODE_UNDERFLOW = 11'h003;
  localparam logic [10:0] CODE_CLK_FAULT = 11'h002;
  localparam logic [10:0] CODE_PAR_FAULT = 11'h001;

  // Command and reply field positions
  localparam int unsigned POS_TOP     = 15;
  localparam int unsigned POS_AD      = 13;
  localparam int unsigned POS_RW      = 12;
  localparam int unsigned POS_PAR_REG = 10;
  localparam int unsigned POS_PAR_ACC = 12;
  // Register replies move the echoed selections down one place
  localparam int unsigned POS_AD_RSP  = 12;
  localparam int unsigned POS_RW_RSP  = 11;

  // Device control register address, the only writable one in normal mode
  localparam logic [7:0] ADDR_DEVICE_CONTROL_REGISTER = 8'h0E;

  typedef struct packed {
    logic transient;
    logic badAxis;
    logic resetExc;
    logic critical;
    logic selfTest;
    logic hold;
    logic clkFault;
    logic parFault;
  } ssrf_exc_s;

  typedef struct packed {
    logic        overflow;
    logic        underflow;
    logic        overRange;
    logic        underRange;
    logic [10:0] value;
  } ssrf_accel_s;
endpackage
`default_nettype wire

// [ssrf_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module ssrf_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Pin in, filtered level out
  input  wire logic pinIn,
  output var  logic levelOut
);
  logic [ssrf_pkg::SYNC_DEPTH-1:0] stage_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_r <= '0;
    end else begin
      stage_r <= {stage_r[ssrf_pkg::SYNC_DEPTH-2:0], pinIn};
    end
  end

  // First stage feeds only the second; stages two and three must agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      levelOut <= 1'b0;
    end else if (stage_r[1] == stage_r[2]) begin
      levelOut <= stage_r[2];
    end
  end
endmodule
`default_nettype wire

// [ssrf_master_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ssrf_master_model #(
  parameter real HALF_NS = 62.5
) (
  // Link pins toward the device
  output var  logic linkSclk,
  output var  logic chipSelect_n,
  output var  logic dataIn,
  // Reply line from the device
  input  wire logic dataOut
);
  initial begin
    linkSclk     = 1'b0;
    chipSelect_n = 1'b1;
    dataIn       = 1'b0;
  end

  // Clock stands low outside frames; slow enough for the 3-flop sampling
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    chipSelect_n = 1'b0;
    #(HALF_NS + 40.0);
    for (int i = 15; i >= 0; i--) begin
      dataIn = cmd[i];
      #(HALF_NS);
      linkSclk = 1'b1;
      rsp[i]   = dataOut;
      #(HALF_NS);
      linkSclk = 1'b0;
    end
    #(HALF_NS);
    chipSelect_n = 1'b1;
    // Released line must not keep the last bit
    dataIn = ~cmd[0];
    #(HALF_NS * 2.0);
  endtask
endmodule
`default_nettype wire

// [test_sensor_spi_response_framer.sv]
`timescale 1ns/10ps
`default_nettype none
module test_sensor_spi_response_framer;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  linkSclk;
  logic                  chipSelect_n;
  logic                  dataIn;
  logic                  dataOut;
  logic                  dataOutEn;
  ssrf_pkg::ssrf_exc_s   exceptions = '0;
  logic                  oscFault = 1'b0;
  logic                  signed_output_select = 1'b0;
  ssrf_pkg::ssrf_accel_s accelX = '{1'b0, 1'b0, 1'b0, 1'b0, 11'h400};
  ssrf_pkg::ssrf_accel_s accelY = '{1'b0, 1'b0, 1'b0, 1'b0, 11'h7FB};
  logic [7:0]            regReadData = 8'h00;
  logic [7:0]            statusCode = 8'h2D;
  logic [7:0]            regPointer;
  logic                  regWrite;
  logic [7:0]            regWriteData;
  logic                  frameDone;
  int                    mismatches = 0;
  int                    checked = 0;
  int                    frames = 0;
  int                    writes = 0;
  int                    dones = 0;
  int                    oeBad = 0;
  logic [10:0]           flagCode [4] = '{11'h7FD, 11'h003, 11'h7FC, 11'h004};

  always #2.5 clk = ~clk;

  ssrf_framer dut_u (.clk(clk), .reset_n(reset_n), .linkSclk(linkSclk), .chipSelect_n(chipSelect_n),
    .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn), .exceptions(exceptions), .oscFault(oscFault),
    .signed_output_select(signed_output_select), .accelX(accelX), .accelY(accelY), .regReadData(regReadData),
    .statusCode(statusCode), .regPointer(regPointer), .regWrite(regWrite), .regWriteData(regWriteData),
    .frameDone(frameDone));

  ssrf_master_model master_u (.linkSclk(linkSclk), .chipSelect_n(chipSelect_n), .dataIn(dataIn), .dataOut(dataOut));

  always @(posedge clk) begin
    if (regWrite === 1'b1) writes++;
    if (frameDone === 1'b1) dones++;
  end

  // Output enable must stand through every frame
  always @(posedge linkSclk) begin
    if (dataOutEn !== 1'b1) oeBad++;
  end

  task automatic give_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Odd parity over the whole frame, parity bit at pos
  function automatic logic [15:0] par(input logic [15:0] r, input int pos);
    logic [15:0] q;
    q      = r;
    q[pos] = ~^r;
    return q;
  endfunction

  function automatic logic [15:0] acc(input logic s, input logic [1:0] t, input logic [10:0] c);
    return par({s, t, 1'b0, c, 1'b0}, 12);
  endfunction

  function automatic logic [15:0] rg(input logic [2:0] s, input logic ad, input logic rw, input logic [1:0] ec,
                                     input logic [7:0] d);
    return par({s, ad, rw, 1'b0, ec, d}, 10);
  endfunction

  // Reply seen in each frame answers the previous command
  task automatic op(input logic [15:0] cmd, input logic [15:0] exp, input string what);
    logic [15:0] r;
    master_u.xfer(cmd, r);
    frames++;
    cmp16(what, exp, r);
  endtask

  task automatic sy();
    @(posedge clk);
    #1;
  endtask

  initial begin
    #300000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (6) sy();
    op(16'h4000, acc(1'b0, 2'h0, 11'h400), "first");
    op(16'h8000, acc(1'b0, 2'h1, 11'h400), "x zero");
    op(16'h8000, acc(1'b0, 2'h2, 11'h7FB), "y max");
    sy();
    signed_output_select = 1'b1;
    op(16'h4000, acc(1'b0, 2'h2, 11'h3FB), "y signed");
    sy();
    signed_output_select = 1'b0;
    for (int k = 0; k < 4; k++) begin
      sy();
      {accelX.overflow, accelX.underflow, accelX.overRange, accelX.underRange} = 4'h8 >> k;
      op(16'h4000, acc(1'b0, 2'h1, flagCode[k]), "x flag");
    end
    sy();
    accelX = '{1'b0, 1'b0, 1'b0, 1'b0, 11'h005};
    op(16'h0400, acc(1'b0, 2'h1, 11'h005), "x min");
    op(16'h140E, rg(3'h0, 1'b0, 1'b0, 2'h0, 8'h00), "ptr read");
    op(16'h345A, rg(3'h0, 1'b0, 1'b1, 2'h0, 8'h00), "ptr write");
    sy();
    regReadData = 8'hC3;
    op(16'h2000, rg(3'h0, 1'b1, 1'b1, 2'h0, 8'h0E), "data write");
    cmp16("wdata", 16'h005A, {8'h00, regWriteData});
    op(16'h1005, rg(3'h0, 1'b1, 1'b0, 2'h0, 8'hC3), "data read");
    op(16'h3411, rg(3'h0, 1'b0, 1'b1, 2'h0, 8'h00), "ptr write 2");
    op(16'h4000, rg(3'h0, 1'b1, 1'b1, 2'h0, 8'h05), "data write 2");
    cmp16("writes", 16'h0001, 16'(writes));
    sy();
    exceptions.critical = 1'b1;
    op(16'h2000, 16'hFFFE, "crit accel");
    sy();
    exceptions = '0;
    exceptions.resetExc = 1'b1;
    op(16'h4000, rg(3'h7, 1'b1, 1'b0, 2'h2, 8'hC3), "crit data read");
    sy();
    exceptions.transient = 1'b1;
    exceptions.clkFault  = 1'b1;
    op(16'h2000, acc(1'b1, 2'h3, 11'h002), "trans accel");
    op(16'h0400, rg(3'h7, 1'b1, 1'b0, 2'h3, 8'h2D), "trans data read");
    sy();
    exceptions = '0;
    exceptions.selfTest = 1'b1;
    op(16'h4000, rg(3'h7, 1'b0, 1'b0, 2'h1, 8'h05), "behav ptr read");
    sy();
    exceptions.hold = 1'b1;
    op(16'h4000, acc(1'b0, 2'h1, 11'h005), "both behav");
    sy();
    exceptions.hold = 1'b0;
    op(16'hC000, acc(1'b1, 2'h1, 11'h005), "behav accel");
    sy();
    exceptions = '0;
    op(16'h4001, acc(1'b1, 2'h3, 11'h7FE), "bad axis");
    op(16'h4000, acc(1'b1, 2'h3, 11'h001), "par fault");
    sy();
    oscFault = 1'b1;
    op(16'h4000, 16'hFFFF, "osc fault");
    sy();
    oscFault = 1'b0;
    repeat (10) sy();
    cmp16("frames", 16'(frames), 16'(dones));
    cmp16("oe frame", 16'h0000, 16'(oeBad));
    cmp16("oe idle", 16'h0000, {15'h0000, dataOutEn});
    give_verdict();
  end
endmodule
`default_nettype wire
